// >>> hdl/mes_pkg.sv
// Constants for the motion event status register block
package mes_pkg;
	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [5:0] IDX_STATUS      = 6'h12;
	localparam logic [5:0] IDX_CTRL        = 6'h20;
	localparam logic [5:0] IDX_OR_LEVEL    = 6'h21;
	localparam logic [5:0] IDX_KNOCK_LEVEL = 6'h22;
	localparam logic [5:0] IDX_KNOCK_DUR   = 6'h23;
	localparam logic [5:0] IDX_KNOCK_LAT   = 6'h24;
	localparam logic [5:0] IDX_KNOCK_WIN   = 6'h25;
	localparam logic [5:0] IDX_INT_STATUS  = 6'h26;
	localparam logic [5:0] IDX_INT_MASK    = 6'h27;
	localparam logic [5:0] IDX_FUSE_FLAGS  = 6'h28;
	// ----------------------------------------
	// Status field positions and reset
	// ----------------------------------------
	localparam int BIT_FUSE    = 7;
	localparam int BIT_STILL   = 6;
	localparam int BIT_MOTION  = 5;
	localparam int BIT_OR_HOLD = 4;
	localparam int BIT_OR_LIVE = 3;
	localparam int BIT_TRIPLE  = 2;
	localparam int BIT_DOUBLE  = 1;
	localparam int BIT_SINGLE  = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] COR_MASK     = 8'hf7;
	// ----------------------------------------
	// Control fields and reset values
	// ----------------------------------------
	localparam int CTRL_DETECT_OFF = 0;
	localparam int CTRL_EDGE_SEL   = 1;
	localparam int CTRL_TRIPLE_EN  = 2;
	localparam int CTRL_SOFT_RESET = 3;
	localparam logic [2:0]  CTRL_RESET        = 3'h0;
	localparam logic [15:0] OR_LEVEL_RESET    = 16'h7fff;
	localparam logic [15:0] KNOCK_LEVEL_RESET = 16'h1000;
	localparam logic [7:0]  KNOCK_DUR_RESET   = 8'h10;
	localparam logic [7:0]  KNOCK_LAT_RESET   = 8'h00;
	localparam logic [7:0]  KNOCK_WIN_RESET   = 8'h00;
	localparam logic [7:0]  INT_MASK_RESET    = 8'h00;
	localparam logic [1:0]  RESP_OKAY         = 2'b00;
	localparam logic [1:0]  RESP_SLVERR       = 2'b10;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TICK_PS       = 500000000;
	localparam int TICK_CYCLES   = TICK_PS / CLK_PERIOD_PS;
	// Settling time kept in ns so no product leaves the int range
	localparam int TICK_NS       = TICK_PS / 1000;
	localparam int SETTLE_NS     = 2500000;
	localparam logic [8:0] SETTLE_TICKS = 9'((SETTLE_NS + TICK_NS - 1) / TICK_NS);
	typedef enum logic [2:0] {
		SEQ_FIRST  = 3'b001,
		SEQ_SECOND = 3'b010,
		SEQ_THIRD  = 3'b100
	} mes_seq_type;
endpackage

// >>> hdl/mes_status_block.sv
// Motion event status register with knock detector, AXI4-Lite slave
//
// What this block does
// - Status at index 0x12, reset 0x00, clear-on-read.
// - Bit 7 sets, holds on uncorrectable fuse error.
// - Bit 7 ORs controller, double-upset, checksum errors.
// - Bit 6 reads 1 on stillness detection.
// - Bit 5 reads 1 on motion over threshold.
// - Bit 4 latches overrange until status read.
// - One status read clears sticky overrange; in live mode only once overrange has ended.
// - Select bit picks overrange trigger, default live.
// - Bit 3 shows live overrange, no latch.
// - Detect-off control suppresses overrange detection.
// - Bit 0 sets on one short knock.
// - Bit 1 needs window, latency nonzero, two knocks.
// - Second knock after latency plus 2.5 ms, inside window.
// - Bit 2 needs triple enable and three knocks.
// - Third knock after latency plus 2.5 ms, inside window.
// - Double-upset flag marks uncorrectable, soft reset clears.
// - Checksum flag marks failed requested checksum check.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module mes_status_block
	import mes_pkg::*;
#(
	parameter int TICK_COUNT = TICK_CYCLES
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] accel_magnitude,
	input  wire logic        accel_valid,
	input  wire logic        stillness_detected,
	input  wire logic        motion_over_threshold,
	input  wire logic        fuse_ctrl_error,
	input  wire logic        fuse_double_upset_detect,
	input  wire logic        fuse_checksum_error_detect,
	output      logic        irq
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction
	function automatic logic mapped(input logic [5:0] idx);
		mapped = (idx == IDX_STATUS) || (idx >= IDX_CTRL && idx <= IDX_FUSE_FLAGS);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]  status;
	logic [2:0]  ctrl;
	logic [15:0] or_level;
	logic [15:0] knock_level_limit;
	logic [7:0]  knock_duration_limit;
	logic [7:0]  knock_latency_time;
	logic [7:0]  knock_window_time;
	logic [7:0]  int_status;
	logic [7:0]  int_mask;
	logic        fuse_double_upset_flag;
	logic        fuse_checksum_error_flag;
	logic [7:0]  aw_idx;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        aw_held;
	logic        w_held;
	logic        or_live_q;
	logic        above_q;
	logic [31:0] tick_cnt;
	logic        tick;
	logic [7:0]  dur_cnt;
	logic [8:0]  gap_cnt;
	logic [8:0]  start_gap;
	mes_seq_type seq;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire        aw_take    = s_axi_awvalid && s_axi_awready;
	wire        w_take     = s_axi_wvalid && s_axi_wready;
	wire        ar_take    = s_axi_arvalid && s_axi_arready;
	wire        aw_have    = aw_held || aw_take;
	wire        w_have     = w_held || w_take;
	wire        do_write   = aw_have && w_have && !s_axi_bvalid;
	wire [7:0]  wr_addr    = aw_held ? aw_idx : s_axi_awaddr;
	wire [31:0] wr_data    = w_held ? w_data : s_axi_wdata;
	wire [3:0]  wr_strb    = w_held ? w_strb : s_axi_wstrb;
	wire [5:0]  wr_idx     = wr_addr[7:2];
	wire [5:0]  rd_idx     = s_axi_araddr[7:2];
	wire        wr_ok      = mapped(wr_idx) && wr_addr[1:0] == 2'b00;
	wire        rd_ok      = mapped(rd_idx) && s_axi_araddr[1:0] == 2'b00;
	wire        wr_lo      = do_write && wr_ok && wr_strb[0];
	wire        wr_ctrl    = wr_lo && wr_idx == IDX_CTRL;
	wire        wr_int     = wr_lo && wr_idx == IDX_INT_STATUS;
	wire        wr_mask    = wr_lo && wr_idx == IDX_INT_MASK;
	wire        wr_or      = do_write && wr_ok && wr_idx == IDX_OR_LEVEL;
	wire        wr_klev    = do_write && wr_ok && wr_idx == IDX_KNOCK_LEVEL;
	wire        wr_kdur    = wr_lo && wr_idx == IDX_KNOCK_DUR;
	wire        wr_klat    = wr_lo && wr_idx == IDX_KNOCK_LAT;
	wire        wr_kwin    = wr_lo && wr_idx == IDX_KNOCK_WIN;
	wire        soft_reset = wr_ctrl && wr_data[CTRL_SOFT_RESET];
	wire        status_rd  = ar_take && rd_idx == IDX_STATUS && s_axi_araddr[1:0] == 2'b00;

	logic [31:0] rd_value;
	always_comb begin
		rd_value = 32'h0000_0000;
		case (rd_idx)
			IDX_STATUS:      rd_value = {24'h000000, status};
			IDX_CTRL:        rd_value = {29'h00000000, ctrl};
			IDX_OR_LEVEL:    rd_value = {16'h0000, or_level};
			IDX_KNOCK_LEVEL: rd_value = {16'h0000, knock_level_limit};
			IDX_KNOCK_DUR:   rd_value = {24'h000000, knock_duration_limit};
			IDX_KNOCK_LAT:   rd_value = {24'h000000, knock_latency_time};
			IDX_KNOCK_WIN:   rd_value = {24'h000000, knock_window_time};
			IDX_INT_STATUS:  rd_value = {24'h000000, int_status};
			IDX_INT_MASK:    rd_value = {24'h000000, int_mask};
			IDX_FUSE_FLAGS:  rd_value = {30'h00000000, fuse_checksum_error_flag, fuse_double_upset_flag};
			default:         rd_value = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_idx        <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_idx        <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			aw_held <= aw_have && !do_write;
			w_held  <= w_have && !do_write;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_ok ? rd_value : 32'h0000_0000;
			s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl                 <= CTRL_RESET;
			or_level             <= OR_LEVEL_RESET;
			knock_level_limit    <= KNOCK_LEVEL_RESET;
			knock_duration_limit <= KNOCK_DUR_RESET;
			knock_latency_time   <= KNOCK_LAT_RESET;
			knock_window_time    <= KNOCK_WIN_RESET;
			int_mask             <= INT_MASK_RESET;
		end else begin
			if (wr_ctrl)
				ctrl <= wr_data[2:0];
			if (wr_or)
				or_level <= merge16(or_level, wr_data, wr_strb);
			if (wr_klev)
				knock_level_limit <= merge16(knock_level_limit, wr_data, wr_strb);
			if (wr_kdur)
				knock_duration_limit <= wr_data[7:0];
			if (wr_klat)
				knock_latency_time <= wr_data[7:0];
			if (wr_kwin)
				knock_window_time <= wr_data[7:0];
			if (wr_mask)
				int_mask <= wr_data[7:0];
		end
	end

	// ----------------------------------------
	// Overrange and fuse flags
	// ----------------------------------------
	wire or_now  = !ctrl[CTRL_DETECT_OFF] && accel_magnitude > or_level;
	wire or_live = !ctrl[CTRL_DETECT_OFF] && or_live_q;
	// Edge mode sees each excursion once, live mode re-arms while it lasts
	wire or_trig = ctrl[CTRL_EDGE_SEL] ? (or_live && !status[BIT_OR_LIVE]) : or_live;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			or_live_q                <= 1'b0;
			fuse_double_upset_flag   <= 1'b0;
			fuse_checksum_error_flag <= 1'b0;
		end else begin
			if (accel_valid)
				or_live_q <= or_now;
			// Detection wins over a soft reset in the same cycle
			fuse_double_upset_flag   <= fuse_double_upset_detect || (fuse_double_upset_flag && !soft_reset);
			fuse_checksum_error_flag <= fuse_checksum_error_detect || (fuse_checksum_error_flag && !soft_reset);
		end
	end

	// ----------------------------------------
	// Knock detector
	// ----------------------------------------
	wire       above     = accel_valid ? accel_magnitude > knock_level_limit : above_q;
	wire       knock_end = above_q && !above;
	wire       knock_ok  = knock_end && dur_cnt < knock_duration_limit;
	wire [8:0] gap_min   = 9'(knock_latency_time) + SETTLE_TICKS;
	wire       in_slot   = start_gap >= gap_min && start_gap <= 9'(knock_window_time);
	wire       seq_armed = knock_window_time != 8'h00 && knock_latency_time != 8'h00;
	logic        set_single;
	logic        set_double;
	logic        set_triple;
	logic        restart_gap;
	mes_seq_type next_seq;
	always_comb begin
		set_single  = 1'b0;
		set_double  = 1'b0;
		set_triple  = 1'b0;
		restart_gap = 1'b0;
		next_seq    = seq;
		case (seq)
			SEQ_FIRST: begin
				if (knock_ok) begin
					set_single  = 1'b1;
					restart_gap = 1'b1;
					next_seq    = seq_armed ? SEQ_SECOND : SEQ_FIRST;
				end
			end
			SEQ_SECOND: begin
				if (knock_ok && in_slot) begin
					set_double  = seq_armed;
					restart_gap = 1'b1;
					next_seq    = ctrl[CTRL_TRIPLE_EN] ? SEQ_THIRD : SEQ_FIRST;
				end else if (knock_ok) begin
					set_single  = 1'b1;
					restart_gap = 1'b1;
				end else if (!above_q && gap_cnt > 9'(knock_window_time)) begin
					next_seq = SEQ_FIRST;
				end
			end
			SEQ_THIRD: begin
				if (knock_ok && in_slot) begin
					set_triple = ctrl[CTRL_TRIPLE_EN];
					next_seq   = SEQ_FIRST;
				end else if (knock_ok) begin
					set_single  = 1'b1;
					restart_gap = 1'b1;
					next_seq    = SEQ_SECOND;
				end else if (!above_q && gap_cnt > 9'(knock_window_time)) begin
					next_seq = SEQ_FIRST;
				end
			end
			default: next_seq = SEQ_FIRST;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= 32'h0000_0000;
			tick     <= 1'b0;
		end else begin
			tick     <= tick_cnt == 32'(TICK_COUNT - 1);
			tick_cnt <= tick_cnt == 32'(TICK_COUNT - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			above_q   <= 1'b0;
			dur_cnt   <= 8'h00;
			gap_cnt   <= 9'h000;
			start_gap <= 9'h000;
			seq       <= SEQ_FIRST;
		end else begin
			above_q <= above;
			seq     <= next_seq;
			if (above && !above_q) begin
				dur_cnt   <= 8'h00;
				start_gap <= gap_cnt;
			end else if (above_q && tick && dur_cnt != 8'hff) begin
				dur_cnt <= dur_cnt + 8'h01;
			end
			if (restart_gap)
				gap_cnt <= 9'h000;
			else if (tick && gap_cnt != 9'h1ff)
				gap_cnt <= gap_cnt + 9'h001;
		end
	end

	// ----------------------------------------
	// Status and interrupt
	// ----------------------------------------
	wire fuse_set = fuse_ctrl_error || fuse_double_upset_flag || fuse_checksum_error_flag;
	logic [7:0] status_set;
	always_comb begin
		status_set              = 8'h00;
		status_set[BIT_FUSE]    = fuse_set;
		status_set[BIT_STILL]   = stillness_detected;
		status_set[BIT_MOTION]  = motion_over_threshold;
		status_set[BIT_OR_HOLD] = or_trig;
		status_set[BIT_TRIPLE]  = set_triple;
		status_set[BIT_DOUBLE]  = set_double;
		status_set[BIT_SINGLE]  = set_single;
	end
	// Set wins over the read clear, so no event slips between capture and clear
	wire [7:0] cor_clear   = status_rd ? COR_MASK : 8'h00;
	wire [7:0] next_status = ((status & ~cor_clear) | status_set) & COR_MASK | {4'h0, or_live, 3'h0};
	wire [7:0] new_events  = status_set & ~status;
	wire [7:0] int_clear   = wr_int ? wr_data[7:0] : 8'h00;
	wire [7:0] next_int    = (int_status & ~int_clear) | new_events;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status     <= STATUS_RESET;
			int_status <= 8'h00;
			irq        <= 1'b0;
		end else begin
			status     <= next_status;
			int_status <= next_int;
			irq        <= |(next_int & int_mask);
		end
	end

endmodule

// >>> tb/mes_host.sv
// AXI4-Lite host model issuing single register cycles
`timescale 1ns/1ps
module mes_host (
	input  wire logic        aclk,
	output      logic [7:0]  s_axi_awaddr = 8'h00,
	output      logic        s_axi_awvalid = 1'b0,
	input  wire logic        s_axi_awready,
	output      logic [31:0] s_axi_wdata = 32'h0,
	output      logic [3:0]  s_axi_wstrb = 4'hf,
	output      logic        s_axi_wvalid = 1'b0,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output      logic        s_axi_bready = 1'b0,
	output      logic [7:0]  s_axi_araddr = 8'h00,
	output      logic        s_axi_arvalid = 1'b0,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output      logic        s_axi_rready = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// >>> tb/mes_status_chk.sv
// Port-level assertions for the motion event status block
`timescale 1ns/1ps
module mes_status_chk
	import mes_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        stillness_detected,
	input wire logic        motion_over_threshold,
	input wire logic        fuse_ctrl_error,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire st_take = s_axi_arvalid && s_axi_arready && s_axi_araddr == {IDX_STATUS, 2'b00};
	wire aw_w    = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	a_still_seen: assert property (st_take && $past(stillness_detected) && $past(aresetn) |=> s_axi_rdata[6])
		else $error("stillness missing from status read");
	a_motion_seen: assert property (st_take && $past(motion_over_threshold) && $past(aresetn) |=> s_axi_rdata[5])
		else $error("motion missing from status read");
	a_fuse_seen: assert property (st_take && $past(fuse_ctrl_error) && $past(aresetn) |=> s_axi_rdata[7])
		else $error("fuse error missing from status read");
	a_status_okay: assert property (st_take |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
		else $error("status read answer wrong");
	a_read_stands: assert property (s_axi_rvalid |=> ($past(s_axi_rready) ? !s_axi_rvalid
		: (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))))
		else $error("read answer dropped or changed");
	a_write_answer: assert property (aw_w |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write answer late");
	a_data_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("read data upper bits set");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
		else $error("outputs busy after reset");
endmodule
bind mes_status_block mes_status_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stillness_detected, .motion_over_threshold, .fuse_ctrl_error, .irq);

// >>> tb/mes_status_block_bench.sv
// Register-level bench for the motion event status block
`timescale 1ns/1ps
module mes_status_block_bench;
	import mes_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, accel_valid, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
	logic [15:0] accel_magnitude;
	logic [4:0]  ev;
	int          miscompares = 0, checked = 0, cycles = 0;
	logic [7:0]  def_addr [9] = '{8'h48, 8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h9c, 8'ha0};
	logic [31:0] def_val [9] = '{32'h0, 32'h0, 32'h7fff, 32'h1000, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0};
	always #2.5 aclk = ~aclk;
	// Short knock tick keeps the knock tests to a few hundred cycles
	mes_status_block #(.TICK_COUNT(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.accel_magnitude, .accel_valid, .stillness_detected(ev[0]), .motion_over_threshold(ev[1]),
		.fuse_ctrl_error(ev[2]), .fuse_double_upset_detect(ev[3]), .fuse_checksum_error_detect(ev[4]), .irq);
	mes_host host_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checked++;
		if (got !== want) begin
			miscompares++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, want);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] want, input logic [1:0] resp = RESP_OKAY);
		host_u.rd(a, rd_d, rd_r);
		chk(rd_d, want);
		chk({30'h0, rd_r}, {30'h0, resp});
	endtask
	task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = RESP_OKAY);
		host_u.wr(a, d, rd_r);
		chk({30'h0, rd_r}, {30'h0, resp});
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic knock(input int n, input int gap);
		repeat (n) begin
			accel_magnitude <= 16'h2000;
			waitc(8);
			accel_magnitude <= 16'h0000;
			waitc(gap);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		aresetn = 1'b0;
		ev = 5'h00;
		accel_magnitude = 16'h0000;
		accel_valid = 1'b0;
		waitc(5);
		aresetn <= 1'b1;
		accel_valid <= 1'b1;
		for (int i = 0; i < 9; i++) rchk(def_addr[i], def_val[i]);
		rchk(8'hfc, 32'h0, RESP_SLVERR);
		wchk(8'h48, 32'hff);
		wchk(8'h81, 32'h1, RESP_SLVERR);
		rchk(8'h48, 32'h0);
		rchk(8'h80, 32'h0);
		$display("test access done");
		// Sources held across reads: set must beat the read clear
		ev <= 5'b00111;
		waitc(2);
		rchk(8'h48, 32'he0);
		rchk(8'h48, 32'he0);
		ev <= 5'b00000;
		waitc(2);
		rchk(8'h48, 32'he0);
		rchk(8'h48, 32'h0);
		$display("test events done");
		for (int i = 0; i < 3; i++) begin
			ev <= 5'(5'b00100 << i);
			waitc(1);
			ev <= 5'b00000;
			waitc(2);
			rchk(8'h48, 32'h80);
			rchk(8'ha0, i == 0 ? 32'h0 : 32'h1 << (i - 1));
			wchk(8'h80, 32'h8);
			rchk(8'ha0, 32'h0);
			host_u.rd(8'h48, rd_d, rd_r);
			rchk(8'h48, 32'h0);
		end
		$display("test fuse done");
		// Knock level out of reach so overrange samples are not knocks
		wchk(8'h88, 32'hffff);
		accel_magnitude <= 16'h8000;
		waitc(3);
		rchk(8'h48, 32'h18);
		accel_magnitude <= 16'h0000;
		waitc(3);
		rchk(8'h48, 32'h10);
		rchk(8'h48, 32'h0);
		wchk(8'h80, 32'h2);
		accel_magnitude <= 16'h8000;
		waitc(3);
		rchk(8'h48, 32'h18);
		rchk(8'h48, 32'h08);
		wchk(8'h80, 32'h1);
		waitc(3);
		rchk(8'h48, 32'h0);
		accel_magnitude <= 16'h0000;
		wchk(8'h80, 32'h0);
		// A level with no valid sample must not reach the live bit
		accel_valid <= 1'b0;
		accel_magnitude <= 16'h8000;
		waitc(3);
		rchk(8'h48, 32'h0);
		accel_magnitude <= 16'h0000;
		accel_valid <= 1'b1;
		$display("test overrange done");
		wchk(8'h88, 32'h1000);
		knock(2, 48);
		rchk(8'h48, 32'h01);
		wchk(8'h90, 32'h1);
		wchk(8'h94, 32'h14);
		knock(2, 48);
		rchk(8'h48, 32'h03);
		knock(2, 8);
		rchk(8'h48, 32'h01);
		knock(2, 120);
		rchk(8'h48, 32'h01);
		wchk(8'h80, 32'h4);
		knock(3, 48);
		rchk(8'h48, 32'h07);
		$display("test knock done");
		wchk(8'h98, 32'hff);
		ev <= 5'b00001;
		waitc(1);
		ev <= 5'b00000;
		waitc(3);
		chk({31'h0, irq}, 32'h0);
		rchk(8'h98, 32'h40);
		wchk(8'h9c, 32'h40);
		waitc(3);
		chk({31'h0, irq}, 32'h1);
		wchk(8'h98, 32'h40);
		waitc(3);
		chk({31'h0, irq}, 32'h0);
		$display("test interrupt done");
		aresetn <= 1'b0;
		waitc(5);
		aresetn <= 1'b1;
		rchk(8'h48, 32'h0);
		rchk(8'h9c, 32'h0);
		$display("test second reset done");
		summarize();
	end
endmodule
